// >>> inc/ipsc_params.svh
`ifndef IPSC_PARAMS_SVH
`define IPSC_PARAMS_SVH
// ==========================================================
// register byte offsets
`define IPSC_OFF_TMR45 12'h010
`define IPSC_OFF_RSVA 12'h014
`define IPSC_OFF_RSVB 12'h018
`define IPSC_OFF_CAP12 12'h01C
`define IPSC_OFF_CAP3 12'h020
`define IPSC_OFF_LOCK 12'h030
// ==========================================================
// field positions
`define IPSC_HI_LSB 8
`define IPSC_LO_LSB 0
`define IPSC_FLD_W 6
// ==========================================================
// reset values
`define IPSC_FLD_RST 6'h3F
`define IPSC_LOCK_RST 1'b0
`endif

// >>> inc/ipsc_pkg.sv
package ipsc_pkg;
   typedef enum logic [2:0] {
      IPSC_SEL_T4,
      IPSC_SEL_T5,
      IPSC_SEL_C1,
      IPSC_SEL_C2,
      IPSC_SEL_C3
   } ipsc_sel_t;
   typedef enum {
      IPSC_APB_IDLE,
      IPSC_APB_SETUP,
      IPSC_APB_ACCESS
   } ipsc_apb_st_t;
endpackage : ipsc_pkg

// >>> rtl/ipsc_field.sv
`timescale 1ns/1ps
`include "ipsc_params.svh"
// ==========================================================
// one 6-bit selector field, reset to all ones
module ipsc_field (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic wr_en,
   input wire logic [5:0] wdata,
   output logic [5:0] value
);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         value <= `IPSC_FLD_RST;
      end else if (wr_en) begin
         value <= wdata;
      end
   end
endmodule : ipsc_field

// >>> rtl/ipsc_pinmux.sv
`timescale 1ns/1ps
`include "ipsc_params.svh"
// ==========================================================
// one pin multiplexer; out-of-range selects idle level
module ipsc_pinmux #(
   parameter int NPINS = 48
) (
   input wire logic [NPINS-1:0] pins,
   input wire logic [5:0] sel,
   input wire logic idle_level,
   output logic out
);
   // refused at elaboration: code 63 must stay unmapped
   if (NPINS < 1 || NPINS > 63) begin : g_bad_npins
      $error("ipsc_pinmux: NPINS out of range");
   end
   always_comb begin
      if (int'(sel) < NPINS) begin
         out = pins[sel];
      end else begin
         out = idle_level;
      end
   end
endmodule : ipsc_pinmux

// >>> rtl/ipsc_top.sv
// Chosen here: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`include "ipsc_params.svh"
// Behaviour
// - upper field of timer reg selects timer5 clock
// - lower field of timer reg selects timer4 clock
// - upper field of capture12 reg selects capture 2
// - lower field of capture12 reg selects capture 1
// - low field of capture3 reg selects capture 3
// - capture3 bits 15..6 read zero, ignored
// - bits above each field read zero
// - all fields and reserved selectors reset one
// - writes ignored while config lock set
module ipsc_top #(
   parameter int NPINS = 48,
   parameter bit IDLE_LEVEL = 1'b0
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic pin_config_lock,
   input wire logic [NPINS-1:0] remappable_io_pin,
   output logic timer4_clk_in,
   output logic timer5_clk_in,
   output logic capture_channel_1,
   output logic capture_channel_2,
   output logic capture_channel_3
);
   // refused at elaboration: the reset code must stay unmapped
   if (NPINS < 1 || NPINS > 63) begin : g_bad_npins
      $error("ipsc_top: NPINS must leave code 63 unmapped");
   end

   // all checks share the bus clock; all but the two reset checks also share the reset
   default clocking cb_chk @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // ==========================================================
   // apb decode
   logic setup_ok;
   logic wr_acc;
   logic hit;
   logic [4:0] fld_we;
   logic [5:0] fld_wd [5];
   logic [5:0] fld_q [5];
   logic [5:0] rsva_hi_ff;
   logic [5:0] rsva_lo_ff;
   logic [5:0] rsvb_hi_ff;
   logic [5:0] rsvb_lo_ff;
   logic [31:0] nxt_rdata;
   logic wr_tmr;
   logic wr_cap12;
   logic wr_cap3;
   logic [29:0] fld_all;
   logic [23:0] rsv_all;

   assign setup_ok = psel && !penable;
   // write lands at the edge where the master samples ready,
   // so the stored value and the bus handshake never disagree
   assign wr_acc = psel && penable && pready && pwrite
      && !pin_config_lock;
   assign wr_tmr = wr_acc && paddr == `IPSC_OFF_TMR45;
   assign wr_cap12 = wr_acc && paddr == `IPSC_OFF_CAP12;
   assign wr_cap3 = wr_acc && paddr == `IPSC_OFF_CAP3;

   always_comb begin
      hit = 1'b1;
      unique case (paddr)
         `IPSC_OFF_TMR45, `IPSC_OFF_RSVA, `IPSC_OFF_RSVB,
         `IPSC_OFF_CAP12, `IPSC_OFF_CAP3, `IPSC_OFF_LOCK: hit = 1'b1;
         default: hit = 1'b0;
      endcase
   end

   // field write enables; bits 7:6 and 15:14 never stored
   always_comb begin
      fld_we = 5'h00;
      fld_we[ipsc_pkg::IPSC_SEL_T4] = wr_tmr;
      fld_we[ipsc_pkg::IPSC_SEL_T5] = wr_tmr;
      fld_we[ipsc_pkg::IPSC_SEL_C1] = wr_cap12;
      fld_we[ipsc_pkg::IPSC_SEL_C2] = wr_cap12;
      fld_we[ipsc_pkg::IPSC_SEL_C3] = wr_cap3;
      fld_wd[0] = pwdata[`IPSC_LO_LSB +: `IPSC_FLD_W];
      fld_wd[1] = pwdata[`IPSC_HI_LSB +: `IPSC_FLD_W];
      fld_wd[2] = pwdata[`IPSC_LO_LSB +: `IPSC_FLD_W];
      fld_wd[3] = pwdata[`IPSC_HI_LSB +: `IPSC_FLD_W];
      fld_wd[4] = pwdata[`IPSC_LO_LSB +: `IPSC_FLD_W];
   end

   // ==========================================================
   // selector fields and muxes
   logic [4:0] mux_o;
   logic [4:0] mux_ff;
   genvar gi;
   generate
      for (gi = 0; gi < 5; gi++) begin : g_sel
         ipsc_field u_fld (
            .pclk(pclk),
            .presetn(presetn),
            .wr_en(fld_we[gi]),
            .wdata(fld_wd[gi]),
            .value(fld_q[gi])
         );
         ipsc_pinmux #(.NPINS(NPINS)) u_mux (
            .pins(remappable_io_pin),
            .sel(fld_q[gi]),
            .idle_level(IDLE_LEVEL),
            .out(mux_o[gi])
         );
      end
   endgenerate

   // registered so every output comes from a flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mux_ff <= {5{IDLE_LEVEL}};
      end else begin
         mux_ff <= mux_o;
      end
   end

   assign timer4_clk_in = mux_ff[0];
   assign timer5_clk_in = mux_ff[1];
   assign capture_channel_1 = mux_ff[2];
   assign capture_channel_2 = mux_ff[3];
   assign capture_channel_3 = mux_ff[4];

   // ==========================================================
   // reserved selectors: stored, reset to ones
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rsva_hi_ff <= `IPSC_FLD_RST;
         rsva_lo_ff <= `IPSC_FLD_RST;
         rsvb_hi_ff <= `IPSC_FLD_RST;
         rsvb_lo_ff <= `IPSC_FLD_RST;
      end else if (wr_acc && paddr == `IPSC_OFF_RSVA) begin
         rsva_hi_ff <= pwdata[`IPSC_HI_LSB +: `IPSC_FLD_W];
         rsva_lo_ff <= pwdata[`IPSC_LO_LSB +: `IPSC_FLD_W];
      end else if (wr_acc && paddr == `IPSC_OFF_RSVB) begin
         rsvb_hi_ff <= pwdata[`IPSC_HI_LSB +: `IPSC_FLD_W];
         rsvb_lo_ff <= pwdata[`IPSC_LO_LSB +: `IPSC_FLD_W];
      end
   end

   // ==========================================================
   // read data
   always_comb begin
      nxt_rdata = 32'h0000_0000;
      unique case (paddr)
         `IPSC_OFF_TMR45: begin
            nxt_rdata = {18'h0, fld_q[1], 2'h0, fld_q[0]};
         end
         `IPSC_OFF_RSVA: nxt_rdata = {18'h0, rsva_hi_ff, 2'h0, rsva_lo_ff};
         `IPSC_OFF_RSVB: nxt_rdata = {18'h0, rsvb_hi_ff, 2'h0, rsvb_lo_ff};
         `IPSC_OFF_CAP12: nxt_rdata = {18'h0, fld_q[3], 2'h0, fld_q[2]};
         `IPSC_OFF_CAP3: nxt_rdata = {26'h0, fld_q[4]};
         `IPSC_OFF_LOCK: nxt_rdata = {31'h0, pin_config_lock};
         default: nxt_rdata = 32'h0000_0000;
      endcase
   end

   // no wait state: answer registered in setup, ready in the first access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= setup_ok;
         pslverr <= setup_ok && !hit;
         prdata <= (setup_ok && !pwrite) ? nxt_rdata : 32'h0000_0000;
      end
   end

   // ==========================================================
   // checks
   assign fld_all = {fld_q[4], fld_q[3], fld_q[2], fld_q[1], fld_q[0]};
   assign rsv_all = {rsva_hi_ff, rsva_lo_ff, rsvb_hi_ff, rsvb_lo_ff};

   // setup phase of any transfer
   sequence seq_setup;
      psel && !penable;
   endsequence

   // access phase that the master completes at this edge
   sequence seq_access;
      psel && penable && pready;
   endsequence

   // completed write to one offset with the lock open
   sequence seq_wr_to(logic [11:0] a);
      seq_access ##0 (pwrite && !pin_config_lock && paddr == a);
   endsequence

   // completed write attempted while the lock is set
   sequence seq_wr_locked;
      seq_access ##0 (pwrite && pin_config_lock);
   endsequence

   // setup of a read from one offset
   sequence seq_rd_from(logic [11:0] a);
      seq_setup ##0 (!pwrite && paddr == a);
   endsequence

   // ==========================================================
   // write path
   AST_LOCK_BLOCKS: assert property (seq_wr_locked |=>
      $stable(fld_all) && $stable(rsv_all))
      else $error("selector changed while locked");

   AST_SETUP_NO_WR: assert property (seq_setup ##0 pwrite |=> // bus timing
      $stable(fld_all) && $stable(rsv_all))
      else $error("write landed in setup phase");

   AST_WR_T4: assert property (seq_wr_to(`IPSC_OFF_TMR45) |=>
      fld_q[0] == $past(pwdata[5:0]))
      else $error("timer4 field not written");

   AST_WR_T5: assert property (seq_wr_to(`IPSC_OFF_TMR45) |=>
      fld_q[1] == $past(pwdata[13:8]))
      else $error("timer5 field not written");

   AST_WR_C1: assert property (seq_wr_to(`IPSC_OFF_CAP12) |=>
      fld_q[2] == $past(pwdata[5:0]))
      else $error("capture1 field not written");

   AST_WR_C2: assert property (seq_wr_to(`IPSC_OFF_CAP12) |=>
      fld_q[3] == $past(pwdata[13:8]))
      else $error("capture2 field not written");

   AST_WR_C3: assert property (seq_wr_to(`IPSC_OFF_CAP3) |=>
      fld_q[4] == $past(pwdata[5:0]))
      else $error("capture3 field not written");

   AST_WR_RSVA: assert property (seq_wr_to(`IPSC_OFF_RSVA) |=>
      rsva_hi_ff == $past(pwdata[13:8])
      && rsva_lo_ff == $past(pwdata[5:0]))
      else $error("reserved a not stored");

   AST_WR_RSVB: assert property (seq_wr_to(`IPSC_OFF_RSVB) |=>
      rsvb_hi_ff == $past(pwdata[13:8])
      && rsvb_lo_ff == $past(pwdata[5:0]))
      else $error("reserved b not stored");

   // ==========================================================
   // read path
   AST_RD_ZERO: assert property (seq_rd_from(`IPSC_OFF_CAP3) |=>
      prdata[31:6] == 26'h0)
      else $error("capture3 upper bits not zero");

   AST_GAP_ZERO: assert property (pready |->
      prdata[7:6] == 2'h0 && prdata[15:14] == 2'h0)
      else $error("unimplemented bits not zero");

   AST_TOP_ZERO: assert property (pready |->
      prdata[31:16] == 16'h0)
      else $error("upper half word not zero");

   AST_RD_T45: assert property (seq_rd_from(`IPSC_OFF_TMR45) |=>
      prdata[13:8] == $past(fld_q[1]) && prdata[5:0] == $past(fld_q[0]))
      else $error("timer fields read back wrong");

   AST_RD_C12: assert property (seq_rd_from(`IPSC_OFF_CAP12) |=>
      prdata[13:8] == $past(fld_q[3]) && prdata[5:0] == $past(fld_q[2]))
      else $error("capture12 fields read back wrong");

   AST_RD_C3: assert property (seq_rd_from(`IPSC_OFF_CAP3) |=>
      prdata[5:0] == $past(fld_q[4]))
      else $error("capture3 field read back wrong");

   AST_RD_LOCK: assert property (seq_rd_from(`IPSC_OFF_LOCK) |=>
      prdata == {31'h0, $past(pin_config_lock)})
      else $error("lock status read back wrong");

   // ==========================================================
   // routing: one flop between field and peripheral input
   AST_MUX_T4: assert property (int'(fld_q[0]) < NPINS |=>
      timer4_clk_in == $past(remappable_io_pin[fld_q[0]]))
      else $error("timer4 clock not routed");

   AST_MUX_T5: assert property (int'(fld_q[1]) < NPINS |=>
      timer5_clk_in == $past(remappable_io_pin[fld_q[1]]))
      else $error("timer5 clock not routed");

   AST_MUX_C1: assert property (int'(fld_q[2]) < NPINS |=>
      capture_channel_1 == $past(remappable_io_pin[fld_q[2]]))
      else $error("capture1 input not routed");

   AST_MUX_C2: assert property (int'(fld_q[3]) < NPINS |=>
      capture_channel_2 == $past(remappable_io_pin[fld_q[3]]))
      else $error("capture2 input not routed");

   AST_MUX_C3: assert property (int'(fld_q[4]) < NPINS |=>
      capture_channel_3 == $past(remappable_io_pin[fld_q[4]]))
      else $error("capture3 input not routed");

   AST_IDLE_T4: assert property (int'(fld_q[0]) >= NPINS |=>
      timer4_clk_in == IDLE_LEVEL)
      else $error("unmapped timer4 select not idle");

   AST_IDLE_T5: assert property (int'(fld_q[1]) >= NPINS |=>
      timer5_clk_in == IDLE_LEVEL)
      else $error("unmapped timer5 select not idle");

   AST_IDLE_C1: assert property (int'(fld_q[2]) >= NPINS |=>
      capture_channel_1 == IDLE_LEVEL)
      else $error("unmapped capture1 select not idle");

   AST_IDLE_C2: assert property (int'(fld_q[3]) >= NPINS |=>
      capture_channel_2 == IDLE_LEVEL)
      else $error("unmapped capture2 select not idle");

   AST_IDLE_MUX: assert property (int'(fld_q[4]) >= NPINS |=>
      capture_channel_3 == IDLE_LEVEL)
      else $error("unmapped select not idle");

   // ==========================================================
   // reset and bus timing
   AST_RST_ONES: assert property (disable iff (1'b0)
      $rose(presetn) |-> fld_all == 30'h3FFF_FFFF && rsv_all == 24'hFF_FFFF)
      else $error("reset value not all ones");

   AST_RST_IDLE: assert property (disable iff (1'b0)
      $rose(presetn) |-> mux_ff == {5{IDLE_LEVEL}} && !pready)
      else $error("outputs not idle after reset");

   AST_READY_NEXT: assert property (seq_setup |=> pready) // bus timing
      else $error("ready missing in access phase");

   AST_READY_ONE: assert property (pready |=> !pready) // bus timing
      else $error("ready longer than one cycle");

   AST_ERR_READY: assert property (pslverr |-> pready) // bus timing
      else $error("error without ready");

   AST_UNMAPPED: assert property (seq_setup ##0 !hit |=> // bus timing
      pslverr && prdata == 32'h0000_0000)
      else $error("unmapped offset not refused");

   AST_RD_QUIET: assert property (!pready |-> // bus timing
      prdata == 32'h0000_0000 && !pslverr)
      else $error("read data outside access phase");
endmodule : ipsc_top

// >>> verif/testbench.sv
`timescale 1ns/1ps
`include "ipsc_params.svh"
// ==========================================================
// bench for the timer and capture input selector
module testbench;
   localparam int NP = 48;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic pin_config_lock = 1'b0;
   logic [NP-1:0] pins = '0;
   logic [4:0] outs;
   logic [31:0] rd;
   logic err;
   int err_total = 0;
   int n_compared = 0;
   // order: timer4, timer5, capture 1, capture 2, capture 3
   logic [11:0] addr_tab [5] = '{`IPSC_OFF_TMR45, `IPSC_OFF_TMR45,
      `IPSC_OFF_CAP12, `IPSC_OFF_CAP12, `IPSC_OFF_CAP3};
   int lsb_tab [5] = '{0, 8, 0, 8, 0};

   always #4 pclk = ~pclk;

   ipsc_top #(.NPINS(NP), .IDLE_LEVEL(1'b0)) uut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr),
      .pin_config_lock(pin_config_lock), .remappable_io_pin(pins),
      .timer4_clk_in(outs[0]), .timer5_clk_in(outs[1]),
      .capture_channel_1(outs[2]), .capture_channel_2(outs[3]),
      .capture_channel_3(outs[4])
   );

   // ==========================================================
   // reporting
   task report_and_stop;
      $display("errors %0d compares %0d", err_total, n_compared);
      if (err_total == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : report_and_stop

   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("Error %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // ==========================================================
   // apb master: hold request until pready seen at an edge
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         n++;
         if (n > 20) begin
            err_total++;
            $display("Error %0t pready never came", $time);
            report_and_stop();
         end
         @(posedge pclk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task rchk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
      chk({31'h0, err}, 32'h0);
   endtask : rchk

   // mux output is registered, so allow a few edges to settle
   task route(input int i, input int p, input logic [NP-1:0] pv,
      input logic e);
      apb(1'b1, addr_tab[i], 32'(p) << lsb_tab[i]);
      pins <= pv;
      repeat (3) @(posedge pclk);
      #1 chk({31'h0, outs[i]}, {31'h0, e});
   endtask : route

   // ==========================================================
   // main sequence
   initial begin
      repeat (12) @(posedge pclk);
      chk({27'h0, outs}, 32'h0);
      presetn <= 1'b1;
      rchk(`IPSC_OFF_TMR45, 32'h3F3F);
      rchk(`IPSC_OFF_RSVA, 32'h3F3F);
      rchk(`IPSC_OFF_RSVB, 32'h3F3F);
      rchk(`IPSC_OFF_CAP12, 32'h3F3F);
      rchk(`IPSC_OFF_CAP3, 32'h3F);
      apb(1'b1, `IPSC_OFF_TMR45, 32'hFFFFFFFF);
      rchk(`IPSC_OFF_TMR45, 32'h3F3F);
      apb(1'b1, `IPSC_OFF_CAP12, 32'hFFFFC0C0);
      rchk(`IPSC_OFF_CAP12, 32'h0);
      apb(1'b1, `IPSC_OFF_CAP3, 32'hFFFFFFFF);
      rchk(`IPSC_OFF_CAP3, 32'h3F);
      // reserved registers only ever written with their ones
      apb(1'b1, `IPSC_OFF_RSVA, 32'h3F3F);
      rchk(`IPSC_OFF_RSVA, 32'h3F3F);
      apb(1'b1, `IPSC_OFF_RSVB, 32'h3F3F);
      rchk(`IPSC_OFF_RSVB, 32'h3F3F);
      for (int i = 0; i < 5; i++) begin
         route(i, 0, NP'(1), 1'b1);
         route(i, NP-1, NP'(1) << (NP-1), 1'b1);
         route(i, NP-1, ~(NP'(1) << (NP-1)), 1'b0);
         route(i, NP, '1, 1'b0);
         route(i, 63, '1, 1'b0);
      end
      apb(1'b1, `IPSC_OFF_TMR45, 32'h0102);
      pin_config_lock <= 1'b1;
      apb(1'b1, `IPSC_OFF_TMR45, 32'h0);
      apb(1'b1, `IPSC_OFF_CAP3, 32'h0);
      rchk(`IPSC_OFF_TMR45, 32'h0102);
      rchk(`IPSC_OFF_CAP3, 32'h3F);
      rchk(`IPSC_OFF_LOCK, 32'h1);
      pin_config_lock <= 1'b0;
      apb(1'b1, `IPSC_OFF_TMR45, 32'h0);
      rchk(`IPSC_OFF_TMR45, 32'h0);
      apb(1'b0, 12'h040, 32'h0);
      chk(rd, 32'h0);
      chk({31'h0, err}, 32'h1);
      // second reset in mid-run brings every field back to ones
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      chk({27'h0, outs}, 32'h0);
      presetn <= 1'b1;
      rchk(`IPSC_OFF_TMR45, 32'h3F3F);
      rchk(`IPSC_OFF_CAP12, 32'h3F3F);
      rchk(`IPSC_OFF_CAP3, 32'h3F);
      report_and_stop();
   end
endmodule : testbench
